// file: rtl/gpio_port.sv
// six-bit port with pull control, alternate functions and pin interrupts behind apb
`include "gpio_port_defs.svh"
`default_nettype none
module gpio_port
    import gpio_port_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sleep_mode,
    input  wire logic        stop_mode,
    input  wire logic [5:0]  pad_in,
    output logic      [5:0]  pad_out,
    output logic      [5:0]  pad_oe,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    input  wire logic [5:0]  alt_out,
    input  wire logic [5:0]  alt_oe,
    output pull_ctrl_t       pulls,
    output logic             external_irq_zero,
    output logic             external_irq_one,
    output logic             reset_pin_n,
    output logic [1:0]       external_irq_flags,
    output logic             tdi_in,
    output logic             tms_in,
    output logic             tck_in,
    input  wire logic        tdo_out,
    input  wire logic        tap_enable
);
    typedef struct packed {
        logic [7:0]  port_output_latch;
        logic [7:0]  port_pullup_select;
        logic [7:0]  port_alternate_function;
        logic [15:0] external_interrupt_control;
        logic [1:0]  flags;
        logic [5:0]  stop_pu;
        logic        stop_prev;
        logic [31:0] rdata;
        logic        err;
    } port_state_t;

    port_state_t s_q;
    port_state_t s_d;
    logic [7:0]  sync_levels;
    logic [5:0]  port_input_levels;
    logic [1:0]  irq_hit;
    irq_cfg_t    cfg0;
    irq_cfg_t    cfg1;
    logic        wr_ok;
    logic [5:0]  nch_on;
    logic [5:0]  pu_on;
    logic [5:0]  own_pin;

    // apply a single-bit set or clear of the bit that wd[2:0] selects, then the mask
    function automatic logic [7:0] bit_op(input logic [7:0] cur, input logic [31:0] wd,
                                          input logic set_op, input logic [7:0] mask);
        logic [7:0] sel;
        sel = 8'h01 << wd[2:0];
        if (set_op)
            bit_op = (cur | sel) & mask;
        else
            bit_op = (cur & ~sel) & mask;
    endfunction

    function automatic logic [7:0] tgt(input logic [31:0] wd, input logic [1:0] idx);
        tgt = {6'h00, 2'(wd[4:`SEL_SHIFT])} == {6'h00, idx} ? 8'hff : 8'h00;
    endfunction

    pin_sync u_sync
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({sda_in, scl_in, pad_in}),
        .sync_out (sync_levels)
    );

    assign port_input_levels = sync_levels[5:0];

    assign cfg0 = '{enable:   s_q.external_interrupt_control[`BIT_PIE],
                    edge_sel: s_q.external_interrupt_control[`BIT_PIT],
                    polarity: s_q.external_interrupt_control[`BIT_PIP]};
    assign cfg1 = '{enable:   s_q.external_interrupt_control[`BIT_PIE + 1],
                    edge_sel: s_q.external_interrupt_control[`BIT_PIT + 1],
                    polarity: s_q.external_interrupt_control[`BIT_PIP + 1]};

    pin_irq_detect u_det0
    (
        .pclk    (pclk),
        .presetn (presetn),
        .cfg     (cfg0),
        .level   (port_input_levels[0]),
        .hit     (irq_hit[0])
    );

    pin_irq_detect u_det1
    (
        .pclk    (pclk),
        .presetn (presetn),
        .cfg     (cfg1),
        .level   (port_input_levels[1]),
        .hit     (irq_hit[1])
    );

    assign wr_ok = psel && penable && pwrite;

    always_comb
    begin
        s_d       = s_q;
        s_d.err   = 1'b0;
        s_d.rdata = 32'h0000_0000;
        s_d.flags = s_q.flags | irq_hit;
        s_d.stop_prev = stop_mode;
        if (stop_mode && !s_q.stop_prev)
            s_d.stop_pu = s_q.port_pullup_select[5:0];
        if (psel && !penable)
        begin
            unique case (paddr)
                `OFF_OUTPUT:    s_d.rdata = {24'h000000, s_q.port_output_latch};
                `OFF_INPUT:     s_d.rdata = {24'h000000, sync_levels[7:6], port_input_levels};
                `OFF_PULLUP:    s_d.rdata = {24'h000000, s_q.port_pullup_select};
                `OFF_ALTFN:     s_d.rdata = {24'h000000, s_q.port_alternate_function};
                `OFF_IRQ_CTRL:  s_d.rdata = {16'h0000, s_q.external_interrupt_control};
                `OFF_IRQ_FLAGS: s_d.rdata = {30'h0, s_q.flags};
                `OFF_BIT_SET,
                `OFF_BIT_CLR:   s_d.rdata = 32'h0000_0000;
                default:        s_d.err   = 1'b1;
            endcase
        end
        if (wr_ok)
        begin
            unique case (paddr)
                `OFF_OUTPUT:
                    if (pstrb[0])
                        s_d.port_output_latch = pwdata[7:0] & `PORT_MASK;
                `OFF_PULLUP:
                    if (pstrb[0])
                        s_d.port_pullup_select = pwdata[7:0] & `PULLUP_MASK;
                `OFF_ALTFN:
                    if (pstrb[0])
                        s_d.port_alternate_function = pwdata[7:0] & `ALTFN_MASK;
                `OFF_IRQ_CTRL:
                begin
                    if (pstrb[0])
                        s_d.external_interrupt_control[7:0] = pwdata[7:0] & 8'(`IRQ_CTRL_MASK);
                end
                `OFF_IRQ_FLAGS:
                    if (pstrb[0])
                        s_d.flags = (s_q.flags & ~pwdata[1:0]) | irq_hit;
                `OFF_BIT_SET,
                `OFF_BIT_CLR:
                begin
                    // pwdata[2:0] bit, pwdata[4:3] register: output, pullup, altfn, irq ctrl
                    if (tgt(pwdata, 2'd0) != 8'h00)
                        s_d.port_output_latch = bit_op(s_q.port_output_latch, pwdata,
                                                       paddr == `OFF_BIT_SET, `PORT_MASK);
                    if (tgt(pwdata, 2'd1) != 8'h00)
                        s_d.port_pullup_select = bit_op(s_q.port_pullup_select, pwdata,
                                                        paddr == `OFF_BIT_SET, `PULLUP_MASK);
                    if (tgt(pwdata, 2'd2) != 8'h00)
                        s_d.port_alternate_function = bit_op(s_q.port_alternate_function, pwdata,
                                                             paddr == `OFF_BIT_SET, `ALTFN_MASK);
                    if (tgt(pwdata, 2'd3) != 8'h00)
                        s_d.external_interrupt_control[7:0] =
                            bit_op(s_q.external_interrupt_control[7:0], pwdata,
                                   paddr == `OFF_BIT_SET, 8'(`IRQ_CTRL_MASK));
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q                            <= '0;
            s_q.port_output_latch          <= `RST_OUTPUT;
            s_q.port_pullup_select         <= `RST_PULLUP;
            s_q.port_alternate_function    <= `RST_ALTFN;
            s_q.external_interrupt_control <= `RST_IRQ_CTRL;
        end
        else
            s_q <= s_d;
    end

    // per-pin drive: the port owns a pin unless its alternate function is on
    always_comb
    begin
        own_pin = ~(s_q.port_alternate_function[5:0] & 6'h07);
        nch_on  = ~s_q.port_output_latch[5:0] & {6{!sleep_mode}};
        pu_on   = s_q.port_output_latch[5:0] & s_q.port_pullup_select[5:0];
        if (stop_mode)
            pu_on = pu_on | s_q.stop_pu;
    end

    always_comb
    begin
        pad_out = 6'h00;
        pad_oe  = 6'h00;
        for (int i = 0; i < 6; i++)
        begin
            if (own_pin[i])
            begin
                pad_out[i] = 1'b0;
                pad_oe[i]  = nch_on[i];
            end
            else
            begin
                pad_out[i] = alt_out[i];
                pad_oe[i]  = alt_oe[i];
            end
        end
        if (tap_enable)
        begin
            pad_out[4] = tdo_out;
            pad_oe[4]  = 1'b1;
        end
    end

    assign pulls.weak_pu   = {2'b00, pu_on[3:0] & own_pin[3:0]};
    assign pulls.strong_pu = {pu_on[5:4], 4'h0};
    assign pulls.serial_pu = {s_q.port_pullup_select[`BIT_SDA_PU], s_q.port_pullup_select[`BIT_SCL_PU]};
    assign pulls.serial_pd = ~pulls.serial_pu;

    assign external_irq_zero  = s_q.port_alternate_function[0] & port_input_levels[0];
    assign external_irq_one   = s_q.port_alternate_function[1] & port_input_levels[1];
    assign reset_pin_n        = !(s_q.port_alternate_function[2] && !s_q.port_alternate_function[`BIT_RESET_PIN_DISABLE])
                                || port_input_levels[2];
    assign external_irq_flags = s_q.flags;
    assign tdi_in             = port_input_levels[0];
    assign tms_in             = port_input_levels[1];
    assign tck_in             = port_input_levels[3];

    assign prdata  = s_q.rdata;
    assign pready  = 1'b1;
    assign pslverr = s_q.err & psel & penable;
endmodule
`default_nettype wire

// file: rtl/gpio_port_defs.svh
// offsets, reset values and field positions for the six-bit port
`ifndef GPIO_PORT_DEFS_SVH
`define GPIO_PORT_DEFS_SVH
`define OFF_OUTPUT      12'h000
`define OFF_INPUT       12'h004
`define OFF_PULLUP      12'h008
`define OFF_ALTFN       12'h00c
`define OFF_IRQ_CTRL    12'h010
`define OFF_IRQ_FLAGS   12'h014
`define OFF_BIT_SET     12'h018
`define OFF_BIT_CLR     12'h01c
`define RST_OUTPUT      8'h3f
`define RST_PULLUP      8'h04
`define RST_ALTFN       8'h04
`define RST_IRQ_CTRL    16'h0000
`define PORT_MASK       8'h3f
`define ALTFN_MASK      8'h47
`define PULLUP_MASK     8'hff
`define IRQ_CTRL_MASK   16'h003f
`define BIT_PIE         0
`define BIT_PIT         2
`define BIT_PIP         4
`define BIT_RESET_PIN_DISABLE        6
`define BIT_SCL_PU      6
`define BIT_SDA_PU      7
`define SEL_SHIFT       3
`endif

// file: rtl/gpio_port_pkg.sv
// types shared by the port files
`default_nettype none
package gpio_port_pkg;
    typedef struct packed {
        logic [5:0] in;
        logic [5:0] out;
        logic [5:0] oe;
    } pad_bus_t;
    typedef struct packed {
        logic [5:0] weak_pu;
        logic [5:0] strong_pu;
        logic [1:0] serial_pd;
        logic [1:0] serial_pu;
    } pull_ctrl_t;
    typedef struct packed {
        logic       enable;
        logic       edge_sel;
        logic       polarity;
    } irq_cfg_t;
endpackage
`default_nettype wire

// file: rtl/pin_irq_detect.sv
// level or edge detector for one pin interrupt
`default_nettype none
module pin_irq_detect
    import gpio_port_pkg::*;
(
    input  wire logic     pclk,
    input  wire logic     presetn,
    input  wire irq_cfg_t cfg,
    input  wire logic     level,
    output logic          hit
);
    typedef struct packed {
        logic prev;
    } det_state_t;
    det_state_t s_q;
    det_state_t s_d;
    logic       is_hit;

    always_comb
    begin
        s_d      = s_q;
        s_d.prev = level;
        if (!cfg.enable)
            is_hit = 1'b0;
        else if (!cfg.edge_sel)
            is_hit = (level == cfg.polarity);
        else
            is_hit = cfg.polarity ? (level && !s_q.prev) : (!level && s_q.prev);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign hit = is_hit;
endmodule
`default_nettype wire

// file: rtl/pin_sync.sv
// two-stage synchroniser for pin inputs
`default_nettype none
module pin_sync
    import gpio_port_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [7:0] async_in,
    output logic      [7:0] sync_out
);
    typedef struct packed {
        logic [7:0] meta;
        logic [7:0] sync;
    } sync_state_t;
    sync_state_t s_q;
    sync_state_t s_d;

    always_comb
    begin
        s_d      = s_q;
        s_d.meta = async_in;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign sync_out = s_q.sync;
endmodule
`default_nettype wire

// file: test/gpio_port_props.sv
// concurrent checks on the port's apb side and pin drive
`default_nettype none
module gpio_port_props
    import gpio_port_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sleep_mode,
    input wire logic [5:0]  pad_in,
    input wire logic [5:0]  pad_out,
    input wire logic [5:0]  pad_oe,
    input wire pull_ctrl_t  pulls,
    input wire logic [1:0]  external_irq_flags,
    input wire logic        tck_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] up_q;
    wire        acc = psel && penable;
    // edges since reset, so the synchroniser has filled
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            up_q <= 2'h0;
        else if (up_q != 2'h3)
            up_q <= up_q + 2'h1;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence wr_out_s;
        acc && pwrite && paddr == 12'h000 && pstrb[0];
    endsequence
    sequence pin3_steady_s;
        (up_q == 2'h3 && $stable(pad_in[3])) [*2];
    endsequence
    AST_READY_NO_WAIT: assert property (acc |-> pready)
        else $error("pready low in access");
    AST_UNMAPPED_ERROR: assert property (acc && paddr > 12'h01c |-> pslverr)
        else $error("no error on unmapped address");
    AST_ERROR_IN_ACCESS_ONLY: assert property (!acc |-> !pslverr)
        else $error("error outside access");
    AST_CLEAR_PULLS_DOWN: assert property (
        wr_out_s ##0 !pwdata[5] ##1 !sleep_mode |-> pad_oe[5] && !pad_out[5] && !pulls.strong_pu[5])
        else $error("pull-down not on after clear");
    AST_SET_RELEASES: assert property (wr_out_s ##0 pwdata[5] |=> !pad_oe[5])
        else $error("pull-down still on after set");
    AST_PULL_STRENGTH: assert property (pulls.weak_pu[5:4] == 2'h0 && pulls.strong_pu[3:0] == 4'h0)
        else $error("wrong pullup strength");
    AST_SLEEP_NO_PULLDOWN: assert property (sleep_mode |-> !pad_oe[5] && !pad_oe[3])
        else $error("pull-down on in sleep");
    AST_FLAG_STICKY: assert property (
        external_irq_flags[0] && !(acc && pwrite && paddr == 12'h014 && pwdata[0]) |=> external_irq_flags[0])
        else $error("flag lost without clear");
    AST_SYNC_TWO_STAGE: assert property (pin3_steady_s |-> tck_in == pad_in[3])
        else $error("pin level not through two stages");
endmodule
bind gpio_port gpio_port_props u_props (.*);
`default_nettype wire

// file: test/pin_board.sv
// board model for the six port pins and the serial lines
`default_nettype none
module pin_board
    import gpio_port_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic [5:0] pad_out,
    input  wire logic [5:0] pad_oe,
    input  wire pull_ctrl_t pulls,
    input  wire logic [5:0] ext_en,
    input  wire logic [5:0] ext_level,
    output logic      [5:0] pad_in,
    output logic            scl_in,
    output logic            sda_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic float_q = 1'b0;
    always @(posedge pclk)
        float_q <= !float_q;
    always_comb
    begin
        for (int i = 0; i < 6; i++)
            if (pad_oe[i])
                pad_in[i] = pad_out[i];
            else if (ext_en[i])
                pad_in[i] = ext_level[i];
            else if (pulls.weak_pu[i] || pulls.strong_pu[i])
                pad_in[i] = 1'b1;
            else
                pad_in[i] = float_q;
        scl_in = pulls.serial_pu[0] || (!pulls.serial_pd[0] && float_q);
        sda_in = pulls.serial_pu[1] || (!pulls.serial_pd[1] && float_q);
    end
endmodule
`default_nettype wire

// file: test/testbench.sv
// self-checking bench for the six-bit port
`default_nettype none
module testbench
    import gpio_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        sleep_mode, stop_mode, scl_in, sda_in, tdo_out, tap_enable;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [5:0]  pad_in, pad_out, pad_oe, alt_out, alt_oe, ext_en, ext_level;
    logic [1:0]  external_irq_flags;
    pull_ctrl_t  pulls;
    logic        external_irq_zero, external_irq_one, reset_pin_n, tdi_in, tms_in, tck_in;
    int          errors = 0;
    int          n_checks = 0;
    always #12.5 pclk = ~pclk;
    gpio_port DUT (.*);
    pin_board u_board (.*);
    task automatic tally_and_finish;
        $display("checks %0d, errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge pclk);
            i++;
        end
        while (pready !== 1'b1 && i < 16);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        if (pready !== 1'b1)
        begin
            errors++;
            tally_and_finish;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask
    task automatic t_reset;
        settle(1);
        chk(32'(pad_oe), 32'h0);
        chk(32'(pulls.serial_pd), 32'h3);
        rdc(12'h000, 32'h3f);
        rdc(12'h008, 32'h04);
        rdc(12'h00c, 32'h04);
        rdc(12'h010, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_drive;
        wr(12'h00c, 32'h0);
        wr(12'h008, 32'h3f);
        wr(12'h000, 32'h2a);
        settle(3);
        chk(32'(pad_oe), 32'h15);
        chk(32'(pulls.weak_pu), 32'h0a);
        chk(32'(pulls.strong_pu), 32'h20);
        rdc(12'h004, 32'h2a);
        settle(0);
        chk(32'(pad_oe), 32'h15);
        wr(12'h008, 32'h0);
        settle(0);
        chk(32'({pulls.weak_pu, pulls.strong_pu}), 32'h0);
        $display("test drive done");
    endtask
    task automatic t_sleep;
        wr(12'h000, 32'h0);
        @(posedge pclk);
        sleep_mode <= 1'b1;
        settle(1);
        chk(32'(pad_oe), 32'h0);
        rdc(12'h000, 32'h0);
        @(posedge pclk);
        sleep_mode <= 1'b0;
        settle(1);
        chk(32'(pad_oe), 32'h3f);
        $display("test sleep done");
    endtask
    task automatic t_stop;
        wr(12'h000, 32'h3f);
        wr(12'h008, 32'h01);
        @(posedge pclk);
        stop_mode <= 1'b1;
        wr(12'h008, 32'h0);
        settle(1);
        chk(32'(pulls.weak_pu), 32'h01);
        @(posedge pclk);
        stop_mode <= 1'b0;
        settle(1);
        chk(32'(pulls.weak_pu), 32'h0);
        $display("test stop done");
    endtask
    task automatic t_bits;
        wr(12'h01c, 32'h03);
        rdc(12'h000, 32'h37);
        wr(12'h018, 32'h03);
        rdc(12'h000, 32'h3f);
        wr(12'h018, 32'h10);
        rdc(12'h00c, 32'h01);
        wr(12'h000, 32'h0);
        settle(0);
        chk(32'(pad_oe), 32'h3e);
        wr(12'h000, 32'h3f);
        $display("test bits done");
    endtask
    task automatic t_irq;
        logic [1:0] m;
        wr(12'h010, 32'hff);
        rdc(12'h010, 32'h3f);
        @(posedge pclk);
        ext_en <= 6'h01;
        for (int k = 0; k < 5; k++)
        begin
            m = k[1:0];
            @(posedge pclk);
            ext_level[0] <= ~m[0];
            wr(12'h010, {27'h0, m[0], 1'b0, m[1], 1'b0, k < 4});
            settle(3);
            wr(12'h014, 32'h3);
            rdc(12'h014, 32'h0);
            @(posedge pclk);
            ext_level[0] <= m[0];
            settle(4);
            rdc(12'h014, 32'(k < 4));
        end
        $display("test irq done");
    endtask
    task automatic t_err;
        apb(1'b0, 12'h020, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b0, 12'h000, 32'h0);
        chk(32'(err), 32'h0);
        $display("test error done");
    endtask
    task automatic t_alt;
        @(posedge pclk);
        {ext_en, ext_level} <= {6'h3f, 6'h0a};
        wr(12'h00c, 32'h07);
        settle(3);
        chk(32'({external_irq_zero, external_irq_one, reset_pin_n}), 32'h2);
        chk(32'({tdi_in, tms_in, tck_in}), 32'h3);
        wr(12'h018, 32'h16);
        rdc(12'h00c, 32'h47);
        chk(32'(reset_pin_n), 32'h1);
        @(posedge pclk);
        {tap_enable, tdo_out} <= 2'b11;
        settle(0);
        chk(32'({pad_oe[4], pad_out[4]}), 32'h3);
        @(posedge pclk);
        tap_enable <= 1'b0;
        wr(12'h008, 32'hc0);
        settle(2);
        chk(32'(pulls.serial_pd), 32'h0);
        rdc(12'h004, 32'hca);
        wr(12'h010, 32'h02);
        wr(12'h014, 32'h3);
        @(posedge pclk);
        ext_level[1] <= 1'b0;
        settle(4);
        rdc(12'h014, 32'h2);
        chk(32'(external_irq_one), 32'h0);
        wr(12'h000, 32'h0);
        @(posedge pclk);
        presetn <= 1'b0;
        settle(0);
        chk(32'({pad_oe, pulls.serial_pd, external_irq_flags}), 32'h0c);
        @(posedge pclk);
        presetn <= 1'b1;
        rdc(12'h000, 32'h3f);
        rdc(12'h014, 32'h0);
        $display("test alt done");
    endtask
    initial
    begin
        {presetn, psel, penable, pwrite, sleep_mode, stop_mode, tdo_out, tap_enable} = 8'h0;
        {paddr, pwdata, pstrb} = {12'h000, 32'h0, 4'hf};
        {alt_out, alt_oe, ext_en, ext_level} = {18'h0, 6'h3f};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_drive;
        t_sleep;
        t_stop;
        t_bits;
        t_irq;
        t_err;
        t_alt;
        tally_and_finish;
    end
endmodule
`default_nettype wire
